// ==== hdl/idxio_ctrl.sv ====
// Controller end: APB registers driving the discrete lines
`timescale 1ns/1ps
`default_nettype none
module idxio_ctrl
    import idxio_pkg::*;
(
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt and run-start setting
    output logic irq,
    output logic [23:0] run_start_timing_setting,
    // Discrete lines
    idxio_if.ctrl link
);
    logic [3:0] ctrl_reg;
    logic [4:0] sel_reg;
    logic [IDXIO_IRQ_W-1:0] irq_stat;
    logic [IDXIO_IRQ_W-1:0] irq_mask;
    logic [15:0] min_interval;
    logic [4:0] prev_code;
    idxio_hstate_t hstate;
    logic setup_ph;
    logic wr_acc;
    logic [IDXIO_IRQ_W-1:0] next_events;
    logic [23:0] run_limit;
    logic mapped;

    assign setup_ph = psel & ~penable;
    assign wr_acc = psel & penable & pready & pwrite;
    assign run_limit = 24'(min_interval) * 24'(IDXIO_RUN_FACTOR);
    assign mapped = paddr[1:0] == 2'b00 && paddr <= IDXIO_OFF_MINT;

    // No wait state: answer is prepared in setup, given in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (ce) begin
            pready <= setup_ph;
            pslverr <= setup_ph & ~mapped;
            if (setup_ph && !pwrite) begin
                unique case (paddr)
                    IDXIO_OFF_CTRL: prdata <= {28'h0, ctrl_reg};
                    IDXIO_OFF_SEL: prdata <= {27'h0, sel_reg};
                    IDXIO_OFF_STAT:
                        prdata <= {26'h0, hstate != IDXIO_H_IDLE,
                                   link.status_lines};
                    IDXIO_OFF_IRQ: prdata <= {29'h0, irq_stat};
                    IDXIO_OFF_MASK: prdata <= {29'h0, irq_mask};
                    IDXIO_OFF_RUN: prdata <= {8'h0, run_start_timing_setting};
                    IDXIO_OFF_MINT: prdata <= {16'h0, min_interval};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Plain register writes; select is frozen while advancing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= IDXIO_CTRL_RST;
            sel_reg <= IDXIO_SEL_RST;
            irq_mask <= IDXIO_IRQ_RST;
            min_interval <= IDXIO_MINT_RST;
        end else if (ce && wr_acc) begin
            if (paddr == IDXIO_OFF_CTRL)
                ctrl_reg <= pwdata[3:0];
            if (paddr == IDXIO_OFF_SEL && hstate == IDXIO_H_IDLE)
                sel_reg <= pwdata[4:0];
            if (paddr == IDXIO_OFF_MASK)
                irq_mask <= pwdata[IDXIO_IRQ_W-1:0];
            if (paddr == IDXIO_OFF_MINT)
                min_interval <= pwdata[15:0];
        end
    end

    // Run-start setting is clamped to its legal maximum on write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_start_timing_setting <= IDXIO_RUN_RST;
        end else if (ce && wr_acc && paddr == IDXIO_OFF_RUN) begin
            if (pwdata[23:0] > run_limit || pwdata[31:24] != 8'h00)
                run_start_timing_setting <= run_limit;
            else
                run_start_timing_setting <= pwdata[23:0];
        end
    end

    // Advance: raise reverse, then pulse advance for one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hstate <= IDXIO_H_IDLE;
        end else if (ce) begin
            unique case (hstate)
                IDXIO_H_IDLE:
                    if (wr_acc && paddr == IDXIO_OFF_CMD &&
                        pwdata[IDXIO_CMD_ADV])
                        hstate <= IDXIO_H_SETUP;
                IDXIO_H_SETUP: hstate <= IDXIO_H_PULSE;
                IDXIO_H_PULSE: hstate <= IDXIO_H_DONE;
                IDXIO_H_DONE: hstate <= IDXIO_H_IDLE;
            endcase
        end
    end

    // Line drivers; an enable drops only once both controls are off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.ctrl_fwd <= 1'b0;
            link.ctrl_rev <= 1'b0;
            link.step_en <= 1'b0;
            link.jog_en <= 1'b0;
            link.advance <= 1'b0;
            link.index_sel <= IDXIO_SEL_RST;
        end else if (ce) begin
            link.index_sel <= sel_reg;
            link.advance <= hstate == IDXIO_H_PULSE;
            link.ctrl_fwd <= ctrl_reg[IDXIO_CTRL_FWD] &
                (ctrl_reg[IDXIO_CTRL_STEP] | ctrl_reg[IDXIO_CTRL_JOG]);
            link.ctrl_rev <= (ctrl_reg[IDXIO_CTRL_REV] &
                (ctrl_reg[IDXIO_CTRL_STEP] | ctrl_reg[IDXIO_CTRL_JOG])) |
                hstate == IDXIO_H_SETUP || hstate == IDXIO_H_PULSE;
            link.step_en <= ctrl_reg[IDXIO_CTRL_STEP] | (link.step_en &
                (link.ctrl_fwd | link.ctrl_rev));
            link.jog_en <= ctrl_reg[IDXIO_CTRL_JOG] | (link.jog_en &
                (link.ctrl_fwd | link.ctrl_rev));
        end
    end

    // Events seen on the status lines
    always_comb begin
        next_events = '0;
        next_events[IDXIO_IRQ_CHANGE] = link.status_lines != prev_code;
        next_events[IDXIO_IRQ_HOMELOST] = prev_code == IDXIO_ST_HOMING &&
            link.status_lines == IDXIO_ST_READY;
        next_events[IDXIO_IRQ_REACHED] = link.status_lines != prev_code &&
            link.status_lines > IDXIO_ST_BASE;
    end

    // Sticky status, write one to clear; a new event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= IDXIO_IRQ_RST;
            prev_code <= IDXIO_ST_ALARM;
            irq <= 1'b0;
        end else if (ce) begin
            prev_code <= link.status_lines;
            if (wr_acc && paddr == IDXIO_OFF_IRQ)
                irq_stat <= (irq_stat & ~pwdata[IDXIO_IRQ_W-1:0]) |
                    next_events;
            else
                irq_stat <= irq_stat | next_events;
            irq <= |((irq_stat | next_events) & irq_mask);
        end
    end
endmodule : idxio_ctrl
`default_nettype wire

// ==== hdl/idxio_pkg.sv ====
// Shared constants and types for the index-mode discrete I/O pair
package idxio_pkg;
    // Status code values on the five output lines
    localparam logic [4:0] IDXIO_ST_ALARM = 5'h00;
    localparam logic [4:0] IDXIO_ST_READY = 5'h01;
    localparam logic [4:0] IDXIO_ST_HOMING = 5'h02;
    localparam logic [4:0] IDXIO_ST_HOMED = 5'h03;
    localparam logic [4:0] IDXIO_ST_MOVING = 5'h04;
    localparam logic [4:0] IDXIO_ST_BASE = 5'h04;
    // Range of index positions that can be reported
    localparam logic [4:0] IDXIO_IDX_FIRST = 5'h01;
    localparam logic [4:0] IDXIO_IDX_LAST = 5'h1b;
    // Run-start setting limit factor
    localparam logic [6:0] IDXIO_RUN_FACTOR = 7'h7d;
    // Controller register byte offsets
    localparam logic [7:0] IDXIO_OFF_CTRL = 8'h00;
    localparam logic [7:0] IDXIO_OFF_SEL = 8'h04;
    localparam logic [7:0] IDXIO_OFF_CMD = 8'h08;
    localparam logic [7:0] IDXIO_OFF_STAT = 8'h0c;
    localparam logic [7:0] IDXIO_OFF_IRQ = 8'h10;
    localparam logic [7:0] IDXIO_OFF_MASK = 8'h14;
    localparam logic [7:0] IDXIO_OFF_RUN = 8'h18;
    localparam logic [7:0] IDXIO_OFF_MINT = 8'h1c;
    // Control register fields
    localparam int IDXIO_CTRL_STEP = 0;
    localparam int IDXIO_CTRL_JOG = 1;
    localparam int IDXIO_CTRL_FWD = 2;
    localparam int IDXIO_CTRL_REV = 3;
    // Command register field
    localparam int IDXIO_CMD_ADV = 0;
    // Status register field above the code
    localparam int IDXIO_STAT_BUSY = 5;
    // Interrupt bits
    localparam int IDXIO_IRQ_CHANGE = 0;
    localparam int IDXIO_IRQ_HOMELOST = 1;
    localparam int IDXIO_IRQ_REACHED = 2;
    localparam int IDXIO_IRQ_W = 3;
    // Reset values
    localparam logic [3:0] IDXIO_CTRL_RST = 4'h0;
    localparam logic [4:0] IDXIO_SEL_RST = 5'h00;
    localparam logic [2:0] IDXIO_IRQ_RST = 3'h0;
    localparam logic [23:0] IDXIO_RUN_RST = 24'h000000;
    localparam logic [15:0] IDXIO_MINT_RST = 16'h0000;
    // Controller advance sequence
    typedef enum logic [1:0] {
        IDXIO_H_IDLE,
        IDXIO_H_SETUP,
        IDXIO_H_PULSE,
        IDXIO_H_DONE
    } idxio_hstate_t;
endpackage : idxio_pkg

// ==== hdl/idxio_if.sv ====
// Discrete lines between the drive and the external controller
`timescale 1ns/1ps
`default_nettype none
interface idxio_if;
    logic [4:0] status_lines; // Drive to controller, 1 = closed
    logic [4:0] index_sel; // Index select lines
    logic ctrl_fwd; // Control 0: forward
    logic ctrl_rev; // Control 1: reverse
    logic step_en; // Manual single step enable
    logic jog_en; // Manual continuous enable
    logic advance; // Step forward to next index
    modport drive (
        output status_lines,
        input index_sel, ctrl_fwd, ctrl_rev, step_en, jog_en, advance
    );
    modport ctrl (
        input status_lines,
        output index_sel, ctrl_fwd, ctrl_rev, step_en, jog_en, advance
    );
endinterface : idxio_if
`default_nettype wire

// ==== hdl/idxio_drive.sv ====
// Drive end: status code encoder and manual index-mode input decode
// What this block does
// - Codes 0-3: alarm, ready, homing, homed
// - Code 4 while moving to index
// - Index n reached gives code n+4
// - One is closed, top line is MSB
// - Ready during homing: clear fault, re-home
// - Run-start setting at most 125 x interval, clamped when written; a later interval write does not re-clamp it
// - One manual velocity for all manual moves
// - Reverse on, select steady before advance
// - Step mode: rising edge gives one step
// - Drop controls before dropping step enable
// - Jog mode: run while control held
// - Drop controls before dropping jog enable
`timescale 1ns/1ps
`default_nettype none
module idxio_drive
    import idxio_pkg::*;
(
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Drive state from the motion core
    input wire logic alarm,
    input wire logic homing_busy,
    input wire logic homing_done,
    input wire logic move_busy,
    input wire logic at_index,
    input wire logic [4:0] cur_index,
    // Manual velocity setting
    input wire logic [15:0] manual_velocity_setting,
    // Motion requests to the motion core
    output logic step_fwd,
    output logic step_rev,
    output logic jog_fwd,
    output logic jog_rev,
    output logic adv_start,
    output logic [4:0] adv_target,
    output logic [15:0] manual_velocity,
    // Discrete lines
    idxio_if.drive link
);
    logic fwd_q;
    logic rev_q;
    logic adv_q;
    logic [4:0] sel_held;
    logic [4:0] next_code;
    logic fwd_rise;
    logic rev_rise;
    logic adv_rise;
    logic index_ok;

    // Valid reported index lies within the encodable range
    function automatic logic in_range(input logic [4:0] idx);
        in_range = idx >= IDXIO_IDX_FIRST && idx <= IDXIO_IDX_LAST;
    endfunction : in_range

    assign index_ok = at_index && in_range(cur_index);

    // Status priority: alarm beats everything, since a faulted drive
    // must not look ready to the controller.
    always_comb begin
        if (alarm)
            next_code = IDXIO_ST_ALARM;
        else if (homing_busy)
            next_code = IDXIO_ST_HOMING;
        else if (move_busy)
            next_code = IDXIO_ST_MOVING;
        else if (index_ok)
            next_code = 5'(cur_index + IDXIO_ST_BASE);
        else if (homing_done)
            next_code = IDXIO_ST_HOMED;
        else
            next_code = IDXIO_ST_READY;
    end

    // Code bit k drives output line k+1, so the top line is the MSB
    // and a one closes the contact.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            link.status_lines <= IDXIO_ST_ALARM;
        else if (ce)
            link.status_lines <= next_code;
    end

    // Previous samples of the control lines for edge detection;
    // inputs are synchronous, so no extra stage is needed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_q <= 1'b0;
            rev_q <= 1'b0;
            adv_q <= 1'b0;
        end else if (ce) begin
            fwd_q <= link.ctrl_fwd;
            rev_q <= link.ctrl_rev;
            adv_q <= link.advance;
        end
    end

    assign fwd_rise = link.ctrl_fwd & ~fwd_q;
    assign rev_rise = link.ctrl_rev & ~rev_q;
    assign adv_rise = link.advance & ~adv_q;

    // Single steps: one pulse per rising edge while step mode is on.
    // Holding a control does not repeat the step.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_fwd <= 1'b0;
            step_rev <= 1'b0;
        end else if (ce) begin
            step_fwd <= link.step_en & fwd_rise;
            step_rev <= link.step_en & rev_rise;
        end
    end

    // Continuous jog follows the control levels; opposed requests
    // cancel rather than pick a direction.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jog_fwd <= 1'b0;
            jog_rev <= 1'b0;
        end else if (ce) begin
            jog_fwd <= link.jog_en & link.ctrl_fwd &
                ~link.ctrl_rev;
            jog_rev <= link.jog_en & link.ctrl_rev &
                ~link.ctrl_fwd;
        end
    end

    // Select value captured as reverse rises; a change before the
    // advance edge makes the advance fall back to index 1.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            sel_held <= 5'h00;
        else if (ce && rev_rise)
            sel_held <= link.index_sel;
    end

    // Advance to the next index; without reverse held or with a
    // changed select the drive falls back to index 1.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adv_start <= 1'b0;
            adv_target <= IDXIO_IDX_FIRST;
        end else if (ce) begin
            adv_start <= adv_rise;
            if (adv_rise) begin
                if (!link.ctrl_rev || link.index_sel != sel_held ||
                    !in_range(cur_index) || cur_index == IDXIO_IDX_LAST)
                    adv_target <= IDXIO_IDX_FIRST;
                else
                    adv_target <= 5'(cur_index + 5'h01);
            end
        end
    end

    // Every manual move uses the same velocity; it is latched as a
    // move starts so a change mid-move cannot alter its speed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            manual_velocity <= 16'h0000;
        else if (ce && (adv_rise || (link.step_en &&
                 (fwd_rise || rev_rise)) || (link.jog_en &&
                 !jog_fwd && !jog_rev)))
            manual_velocity <= manual_velocity_setting;
    end
endmodule : idxio_drive
`default_nettype wire

// ==== test/idxio_sva.sv ====
// Link and drive-output checks for the index-mode discrete I/O pair
`timescale 1ns/1ps
`default_nettype none
module idxio_sva
    import idxio_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link lines
    input wire logic [4:0] status_lines,
    input wire logic [4:0] index_sel,
    input wire logic ctrl_fwd,
    input wire logic ctrl_rev,
    input wire logic step_en,
    input wire logic jog_en,
    input wire logic advance,
    // Drive state and motion requests
    input wire logic alarm,
    input wire logic homing_busy,
    input wire logic move_busy,
    input wire logic at_index,
    input wire logic [4:0] cur_index,
    input wire logic step_fwd,
    input wire logic jog_fwd,
    input wire logic jog_rev,
    input wire logic adv_start
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Alarm and homing outrank every lower status
    logic calm;
    logic ctl_idle;
    assign calm = !alarm && !homing_busy;
    assign ctl_idle = !ctrl_fwd && !ctrl_rev;
    // A step or advance request lasts exactly one cycle, then drops
    sequence one_pulse(p);
        p ##1 !p;
    endsequence
    alarm_code_a: assert property (alarm
        |=> status_lines == IDXIO_ST_ALARM) else $error("alarm code wrong");
    homing_code_a: assert property (!alarm && homing_busy
        |=> status_lines == IDXIO_ST_HOMING) else $error("homing code wrong");
    moving_code_a: assert property (calm && move_busy
        |=> status_lines == IDXIO_ST_MOVING) else $error("moving code wrong");
    index_code_a: assert property (calm && !move_busy && at_index
        && cur_index inside {[1:27]}
        |=> status_lines == $past(cur_index) + IDXIO_ST_BASE)
        else $error("index code wrong");
    step_fwd_a: assert property (step_en && $rose(ctrl_fwd)
        |=> one_pulse(step_fwd)) else $error("step pulse wrong");
    jog_fwd_a: assert property (jog_en && ctrl_fwd && !ctrl_rev
        |=> jog_fwd && !jog_rev) else $error("jog forward wrong");
    jog_both_a: assert property (jog_en && ctrl_fwd && ctrl_rev
        |=> !jog_fwd && !jog_rev) else $error("jog with both on");
    adv_start_a: assert property ($rose(advance)
        |=> one_pulse(adv_start)) else $error("advance start wrong");
    adv_order_a: assert property (advance
        |-> ctrl_rev && $past(ctrl_rev) && $stable(index_sel))
        else $error("advance without reverse held");
    step_exit_a: assert property ($fell(step_en) |-> $past(ctl_idle))
        else $error("step enable dropped with control on");
    jog_exit_a: assert property ($fell(jog_en) |-> $past(ctl_idle))
        else $error("jog enable dropped with control on");
endmodule : idxio_sva
`default_nettype wire

// ==== test/index_mode_io_sequencer_test.sv ====
// Self-checking bench for the drive and controller pair
`timescale 1ns/1ps
`default_nettype none
module index_mode_io_sequencer_test
    import idxio_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic alarm = 1, homing_busy = 0, homing_done = 0, move_busy = 0;
    logic at_index = 0, pready, pslverr, irq, step_fwd, step_rev, err;
    logic jog_fwd, jog_rev, adv_start;
    logic [4:0] cur_index = 0, adv_target, last_tgt, last_code;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, seed = 32'h0001015e;
    logic [15:0] vel = 0, mvel;
    logic [23:0] run_set;
    int n_errors = 0, checks_done = 0, cyc = 0, n_sf = 0, n_sr = 0, n_adv = 0;
    always #5 pclk = ~pclk;
    idxio_if link_if ();
    idxio_drive idxio_drive_i (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .alarm(alarm), .homing_busy(homing_busy), .homing_done(homing_done),
        .move_busy(move_busy), .at_index(at_index), .cur_index(cur_index),
        .manual_velocity_setting(vel), .step_fwd(step_fwd),
        .step_rev(step_rev), .jog_fwd(jog_fwd), .jog_rev(jog_rev),
        .adv_start(adv_start), .adv_target(adv_target),
        .manual_velocity(mvel), .link(link_if));
    idxio_ctrl idxio_ctrl_i (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .run_start_timing_setting(run_set),
        .link(link_if));
    idxio_sva idxio_sva_i (.pclk(pclk), .presetn(presetn),
        .status_lines(link_if.status_lines), .index_sel(link_if.index_sel),
        .ctrl_fwd(link_if.ctrl_fwd), .ctrl_rev(link_if.ctrl_rev),
        .step_en(link_if.step_en), .jog_en(link_if.jog_en),
        .advance(link_if.advance), .alarm(alarm), .homing_busy(homing_busy),
        .move_busy(move_busy), .at_index(at_index), .cur_index(cur_index),
        .step_fwd(step_fwd), .jog_fwd(jog_fwd), .jog_rev(jog_rev),
        .adv_start(adv_start));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // Priority order of the status code; f = alarm,homing,homed,moving,at
    function automatic logic [4:0] exp_code(logic [4:0] f, logic [4:0] ci);
        if (f[4]) return IDXIO_ST_ALARM;
        if (f[3]) return IDXIO_ST_HOMING;
        if (f[1]) return IDXIO_ST_MOVING;
        if (f[0] && ci >= IDXIO_IDX_FIRST && ci <= IDXIO_IDX_LAST)
            return ci + IDXIO_ST_BASE;
        if (f[2]) return IDXIO_ST_HOMED;
        return IDXIO_ST_READY;
    endfunction : exp_code
    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (!ok) begin
            n_errors++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : chk
    // Pready is sampled at the rising edge with psel and penable high;
    // data is taken at that edge and only then is the request released
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic settle();
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask : settle
    task automatic set_st(input logic [4:0] f, input logic [4:0] ci);
        @(posedge pclk);
        {alarm, homing_busy, homing_done, move_busy, at_index} <= f;
        cur_index <= ci;
        last_code = exp_code(f, ci);
        settle();
        chk(link_if.status_lines === last_code, "status code");
    endtask : set_st
    task automatic jog(input logic [31:0] d, input logic [1:0] e);
        apb(1'b1, IDXIO_OFF_CTRL, d);
        settle();
        chk({jog_fwd, jog_rev} === e, "jog request");
    endtask : jog
    task automatic adv(input logic [4:0] from, input logic [4:0] want);
        int n;
        set_st(5'h01, from);
        n = n_adv;
        apb(1'b1, IDXIO_OFF_CMD, 32'h1);
        apb(1'b0, IDXIO_OFF_STAT, 32'h0);
        chk(rd[IDXIO_STAT_BUSY] === 1'b1, "advance busy");
        while (n_adv == n) @(posedge pclk);
        chk(last_tgt === want, "advance target");
    endtask : adv
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    // Pulse counters and the hang guard
    always @(posedge pclk) begin
        cyc++;
        if (step_fwd === 1'b1) n_sf++;
        if (step_rev === 1'b1) n_sr++;
        if (adv_start === 1'b1) begin
            n_adv++;
            last_tgt = adv_target;
        end
        if (cyc > 5000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        vel <= 16'(xs());
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, IDXIO_OFF_RUN, 32'h0);
        chk(rd[23:0] === IDXIO_RUN_RST, "run reset value");
        apb(1'b1, IDXIO_OFF_MASK, 32'h7);
        set_st(5'h08, 5'h00);
        set_st(5'h00, 5'h00);
        apb(1'b0, IDXIO_OFF_IRQ, 32'h0);
        chk(irq === 1'b1 && rd[2:0] === 3'h3, "home lost event");
        apb(1'b1, IDXIO_OFF_IRQ, 32'h7);
        settle();
        chk(irq === 1'b0, "irq clear");
        apb(1'b1, IDXIO_OFF_MASK, 32'h0);
        set_st(5'h01, IDXIO_IDX_LAST);
        chk(irq === 1'b0, "irq masked");
        apb(1'b0, IDXIO_OFF_IRQ, 32'h0);
        chk(rd[2:0] === 3'h5, "irq pending");
        apb(1'b1, IDXIO_OFF_IRQ, 32'h7);
        $display("interrupt test done");
        set_st(5'h10, 5'h00);
        set_st(5'h04, 5'h00);
        set_st(5'h02, 5'h00);
        for (int i = 0; i < 32; i++) set_st(5'h01, 5'(i));
        repeat (40) set_st(5'(xs()), 5'(xs() >> 7));
        apb(1'b0, IDXIO_OFF_STAT, 32'h0);
        chk(rd[4:0] === last_code, "status register");
        $display("status code test done");
        apb(1'b1, IDXIO_OFF_CTRL, 32'h1);
        apb(1'b1, IDXIO_OFF_CTRL, 32'h5);
        repeat (8) @(posedge pclk);
        apb(1'b1, IDXIO_OFF_CTRL, 32'h1);
        apb(1'b1, IDXIO_OFF_CTRL, 32'h9);
        apb(1'b1, IDXIO_OFF_CTRL, 32'h1);
        apb(1'b1, IDXIO_OFF_CTRL, 32'h0);
        settle();
        chk(n_sf == 1 && n_sr == 1, "single step count");
        // Enable and control dropped in one write: enable must lag
        apb(1'b1, IDXIO_OFF_CTRL, 32'h5);
        apb(1'b1, IDXIO_OFF_CTRL, 32'h0);
        settle();
        chk(n_sf == 2 && link_if.step_en === 1'b0, "step exit");
        $display("single step test done");
        vel <= 16'(xs());
        jog(32'h6, 2'b10);
        jog(32'he, 2'b00);
        jog(32'ha, 2'b01);
        jog(32'h2, 2'b00);
        jog(32'h6, 2'b10);
        apb(1'b1, IDXIO_OFF_CTRL, 32'h0);
        chk(mvel === vel, "manual velocity");
        settle();
        chk(jog_fwd === 1'b0 && link_if.jog_en === 1'b0, "jog exit");
        $display("jog test done");
        apb(1'b1, IDXIO_OFF_SEL, xs() & 32'h1f);
        adv(5'h05, 5'h06);
        adv(5'h1a, 5'h1b);
        adv(5'h1b, 5'h01);
        $display("advance test done");
        apb(1'b1, IDXIO_OFF_MINT, 32'h1);
        apb(1'b1, IDXIO_OFF_RUN, 32'hc8);
        apb(1'b0, IDXIO_OFF_RUN, 32'h0);
        chk(rd[23:0] === 24'h7d && run_set === 24'h7d, "run clamp");
        apb(1'b0, 8'h20, 32'h0);
        chk(err === 1'b1, "unmapped address");
        apb(1'b0, 8'h02, 32'h0);
        chk(err === 1'b1, "misaligned address");
        $display("register test done");
        end_of_test();
    end
endmodule : index_mode_io_sequencer_test
`default_nettype wire
